// ### rtl/prps_top.sv
// Purpose: Reference path selection and configuration for a PLL clock generator.
// Assumes: Single 100 MHz ref_clk, synchronous active-high srst, plain register port.
// Notes: Reads return data one cycle after the strobe; unmapped reads give zero.
`timescale 1ns/1ps
module prps_top import prps_pkg::*; (
    input wire logic ref_clk, // 100 MHz system clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, one cycle later
    input wire logic input_choice_pin, // Reference select pin, asynchronous
    output logic ref_is_diff, // 1 when differential reference chosen
    output logic [INTYPE_W-1:0] xtal_in_type, // Crystal-side input stage
    output logic [INTYPE_W-1:0] diff_in_type, // Differential input stage
    output logic doubler_on, // Frequency doubler active
    output logic [RDIV_W-1:0] pre_pfd_divide_value, // Applied divide ratio
    output logic [BYP_SRC_W-1:0] bypass_source_sel, // Bypass path source
    output logic [BYP_CH_W-1:0] bypass_chan_buf_on, // Channel 4..1 bypass buffers
    output logic bypass_single_out_on, // Single-ended bypass buffer
    output logic zero_delay_on, // Zero-delay mode active
    output logic ext_fb_pos_en, // Use positive external feedback pin
    output logic ext_fb_neg_en, // Use negative external feedback pin
    output logic int_fb_ch2_en // Internal feedback from channel 2
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic pin_sync; // Select pin after two flops

    prps_sync2 u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .din(input_choice_pin),
        .dout(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    prps_cfg_t cfg_reg; // Stored configuration
    prps_cfg_t cfg_next; // Next configuration

    // Writes update fields; apart from reset, nothing else changes them
    always_comb begin
        cfg_next = cfg_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_REFCTL: begin
                    cfg_next.src_reg = reg_wdata[REFCTL_SRC_BIT];
                    cfg_next.mux_reg = reg_wdata[REFCTL_MUX_BIT];
                    cfg_next.xtype = reg_wdata[REFCTL_XTYPE_LSB +: INTYPE_W];
                    cfg_next.dtype = reg_wdata[REFCTL_DTYPE_LSB +: INTYPE_W];
                end
                OFS_RDIV: begin
                    cfg_next.rdiv = reg_wdata[RDIV_W-1:0];
                end
                OFS_BYP: begin
                    cfg_next.byp_src = reg_wdata[BYP_SRC_LSB +: BYP_SRC_W];
                    cfg_next.byp_ch = reg_wdata[BYP_CH_LSB +: BYP_CH_W];
                    cfg_next.byp_y0 = reg_wdata[BYP_Y0_BIT];
                end
                OFS_ZDM: begin
                    cfg_next.zdm_on = reg_wdata[ZDM_MODE_BIT];
                    cfg_next.zdm_fb = reg_wdata[ZDM_FB_BIT];
                    cfg_next.zdm_auto = reg_wdata[ZDM_AUTO_BIT];
                    cfg_next.fb_diff = reg_wdata[ZDM_DIFF_BIT];
                end
                default: begin
                    // Unmapped or read-only offset: write ignored
                end
            endcase
        end
    end

    // Reset gives normal PLL, pin-steered, divide by one
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_reg <= '0;
            cfg_reg.rdiv <= RDIV_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Path resolution

    prps_path_t path_now; // Combinational resolved path
    prps_path_t path_reg; // Registered path
    prps_path_t path_next; // Next registered path

    prps_resolve u_res (
        .cfg(cfg_reg),
        .pin_sel(pin_sync),
        .path(path_now)
    );

    // Register resolved path so outputs come from flops
    always_comb begin
        path_next = path_now;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            path_reg <= '0;
            path_reg.div_val <= RDIV_RESET;
        end else begin
            path_reg <= path_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    logic [DATA_W-1:0] rdata_next; // Next read data

    // Read mux; unmapped reads return zero
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_REFCTL: begin
                    rdata_next[REFCTL_SRC_BIT] = cfg_reg.src_reg;
                    rdata_next[REFCTL_MUX_BIT] = cfg_reg.mux_reg;
                    rdata_next[REFCTL_XTYPE_LSB +: INTYPE_W] = cfg_reg.xtype;
                    rdata_next[REFCTL_DTYPE_LSB +: INTYPE_W] = cfg_reg.dtype;
                end
                OFS_RDIV: begin
                    rdata_next[RDIV_W-1:0] = cfg_reg.rdiv;
                end
                OFS_BYP: begin
                    rdata_next[BYP_SRC_LSB +: BYP_SRC_W] = cfg_reg.byp_src;
                    rdata_next[BYP_CH_LSB +: BYP_CH_W] = cfg_reg.byp_ch;
                    rdata_next[BYP_Y0_BIT] = cfg_reg.byp_y0;
                end
                OFS_ZDM: begin
                    rdata_next[ZDM_MODE_BIT] = cfg_reg.zdm_on;
                    rdata_next[ZDM_FB_BIT] = cfg_reg.zdm_fb;
                    rdata_next[ZDM_AUTO_BIT] = cfg_reg.zdm_auto;
                    rdata_next[ZDM_DIFF_BIT] = cfg_reg.fb_diff;
                end
                OFS_STAT: begin
                    // Live state: which reference, doubler, zero-delay, external feedback, pin level
                    rdata_next[STAT_REF_BIT] = path_reg.ref_sel;
                    rdata_next[STAT_DBL_BIT] = path_reg.dbl_on;
                    rdata_next[STAT_ZDM_BIT] = path_reg.zdm_act;
                    rdata_next[STAT_FBX_BIT] = path_reg.fb_ext;
                    rdata_next[STAT_PIN_BIT] = pin_sync;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    always_comb begin
        ref_is_diff = path_reg.ref_sel;
        xtal_in_type = path_reg.in_type;
        diff_in_type = cfg_reg.dtype;
        doubler_on = path_reg.dbl_on;
        pre_pfd_divide_value = path_reg.div_val;
        bypass_source_sel = path_reg.byp_src;
        bypass_chan_buf_on = path_reg.byp_ch;
        bypass_single_out_on = path_reg.byp_y0;
        zero_delay_on = path_reg.zdm_act;
        ext_fb_pos_en = path_reg.fb_ext;
        ext_fb_neg_en = path_reg.fb_neg_used;
        int_fb_ch2_en = path_reg.fb_int_ch2;
    end

endmodule

// ### rtl/prps_pkg.sv
// Purpose: Shared constants and types for the reference path selector.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Register offsets, field widths and reset values live here.
package prps_pkg;

    localparam int ADDR_W = 4; // Register address width
    localparam int DATA_W = 32; // Register data width

    // Register offsets
    localparam logic [3:0] OFS_REFCTL = 4'h0; // Reference choice and input type
    localparam logic [3:0] OFS_RDIV = 4'h1; // Pre-PFD divide value
    localparam logic [3:0] OFS_BYP = 4'h2; // Bypass source and buffer enables
    localparam logic [3:0] OFS_ZDM = 4'h3; // Zero-delay control
    localparam logic [3:0] OFS_STAT = 4'h4; // Resolved path status, read only

    // Field positions in REFCTL
    localparam int REFCTL_SRC_BIT = 0; // Choice driven by register when set
    localparam int REFCTL_MUX_BIT = 1; // Register choice: 1 selects differential
    localparam int REFCTL_XTYPE_LSB = 4; // Crystal-side input type
    localparam int REFCTL_DTYPE_LSB = 8; // Differential input type
    localparam int INTYPE_W = 2; // Width of an input type field

    // Field positions in BYP
    localparam int BYP_SRC_LSB = 0; // Bypass source select
    localparam int BYP_SRC_W = 2; // Width of bypass source select
    localparam int BYP_CH_LSB = 4; // Channel buffer enables 4..1
    localparam int BYP_CH_W = 4; // Number of bypass channel buffers
    localparam int BYP_Y0_BIT = 8; // Single-ended bypass buffer enable

    // Field positions in ZDM
    localparam int ZDM_MODE_BIT = 0; // Zero-delay mode on
    localparam int ZDM_FB_BIT = 1; // Feedback choice: 0 internal, 1 external
    localparam int ZDM_AUTO_BIT = 2; // Automatic zero-delay
    localparam int ZDM_DIFF_BIT = 3; // External feedback is differential

    // Field positions in STAT, read only
    localparam int STAT_REF_BIT = 0; // Differential reference in use
    localparam int STAT_DBL_BIT = 1; // Doubler active
    localparam int STAT_ZDM_BIT = 2; // Zero-delay active
    localparam int STAT_FBX_BIT = 3; // External feedback in use
    localparam int STAT_PIN_BIT = 4; // Synchronised select pin level

    // Divide field
    localparam int RDIV_W = 8; // Pre-PFD divide value width
    localparam logic [7:0] RDIV_DOUBLER = 8'h00; // Zero turns on the doubler
    localparam logic [7:0] RDIV_RESET = 8'h01; // Divide by one after reset

    // Bypass source encodings
    localparam logic [1:0] BYP_SEL_REF = 2'h0; // Selected input reference
    localparam logic [1:0] BYP_SEL_PFD = 2'h1; // Phase-detector input
    localparam logic [1:0] BYP_SEL_DIV = 2'h2; // Divider or doubler output (debug)

    // Reference choice
    typedef enum logic [0:0] {
        PRPS_REF_XTAL = 1'b0,
        PRPS_REF_DIFF = 1'b1
    } prps_ref_t;

    // Configuration carried between modules
    typedef struct packed {
        logic src_reg; // Register steers the mux
        logic mux_reg; // Register choice
        logic [1:0] xtype; // Crystal-side input type
        logic [1:0] dtype; // Differential input type
        logic [7:0] rdiv; // Pre-PFD divide value
        logic [1:0] byp_src; // Bypass source
        logic [3:0] byp_ch; // Channel bypass buffers
        logic byp_y0; // Single-ended bypass buffer
        logic zdm_on; // Zero-delay mode
        logic zdm_fb; // Feedback choice
        logic zdm_auto; // Automatic zero-delay
        logic fb_diff; // Differential external feedback
    } prps_cfg_t;

    // Resolved path controls
    typedef struct packed {
        prps_ref_t ref_sel; // Reference to PLL and distribution
        logic [1:0] in_type; // Input stage for the crystal-side pins
        logic dbl_on; // Frequency doubler active
        logic [7:0] div_val; // Divide ratio applied (1..255)
        logic [1:0] byp_src; // Bypass source
        logic [3:0] byp_ch; // Channel bypass buffers
        logic byp_y0; // Single-ended bypass buffer
        logic zdm_act; // Zero-delay valid and active
        logic fb_ext; // External feedback used
        logic fb_neg_used; // Negative feedback pin used
        logic fb_int_ch2; // Internal feedback from channel 2
    } prps_path_t;

endpackage

// ### rtl/prps_sync2.sv
// Purpose: Two-flop synchroniser for a level from a pin.
// Assumes: Input is asynchronous to ref_clk.
// Notes: First stage feeds only the second.
`timescale 1ns/1ps
module prps_sync2 import prps_pkg::*; (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic din, // Asynchronous level
    output logic dout // Synchronised level
);
    logic meta_reg; // First stage
    logic meta_next; // First stage next
    logic sync_next; // Second stage next

    // Shift the level through two stages
    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    // Register both stages
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            dout <= sync_next;
        end
    end
endmodule

// ### rtl/prps_resolve.sv
// Purpose: Combinational resolution of configuration into path controls.
// Assumes: Select pin already synchronised.
// Notes: Output is registered by the caller.
`timescale 1ns/1ps
module prps_resolve import prps_pkg::*; (
    input wire prps_cfg_t cfg, // Stored configuration
    input wire logic pin_sel, // Synchronised select pin
    output prps_path_t path // Resolved controls
);
    // Work out each control from the fields
    always_comb begin
        path = '0;
        if (cfg.zdm_on && cfg.zdm_auto && cfg.src_reg && cfg.mux_reg
                && cfg.rdiv == RDIV_RESET) begin
            path.zdm_act = 1'b1;
        end
        if (path.zdm_act) begin
            path.ref_sel = PRPS_REF_DIFF;
        end else if (cfg.src_reg) begin
            path.ref_sel = prps_ref_t'(cfg.mux_reg);
        end else begin
            path.ref_sel = prps_ref_t'(pin_sel);
        end
        path.in_type = cfg.xtype;
        path.dbl_on = (cfg.rdiv == RDIV_DOUBLER);
        path.div_val = path.dbl_on ? RDIV_RESET : cfg.rdiv;
        path.byp_src = cfg.byp_src;
        path.byp_ch = cfg.byp_ch;
        path.byp_y0 = cfg.byp_y0;
        path.fb_ext = path.zdm_act && cfg.zdm_fb;
        path.fb_neg_used = path.fb_ext && cfg.fb_diff;
        path.fb_int_ch2 = path.zdm_act && !cfg.zdm_fb;
    end
endmodule

// ### verification/prps_chk.sv
// Purpose: Port-level timing checks for the reference path selector.
// Assumes: Sees only prps_top ports; one clock domain.
// Notes: Path outputs follow a write by two edges (cfg flop, path flop).
`timescale 1ns/1ps
module prps_chk import prps_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic [ADDR_W-1:0] reg_addr, // Address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // Read data
    input wire logic ref_is_diff, // Differential chosen
    input wire logic doubler_on, // Doubler active
    input wire logic [RDIV_W-1:0] pre_pfd_divide_value, // Divide ratio
    input wire logic [BYP_SRC_W-1:0] bypass_source_sel, // Bypass source
    input wire logic [BYP_CH_W-1:0] bypass_chan_buf_on, // Channel buffers
    input wire logic bypass_single_out_on, // Single-ended buffer
    input wire logic zero_delay_on, // Zero-delay active
    input wire logic ext_fb_pos_en, // External feedback
    input wire logic ext_fb_neg_en, // Differential feedback
    input wire logic int_fb_ch2_en // Internal feedback
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Write steps that start a two-edge update
    sequence s_rdiv_wr;
        reg_wr && reg_addr == OFS_RDIV;
    endsequence
    sequence s_byp_wr;
        reg_wr && reg_addr == OFS_BYP;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read reply");
    a_div_write: assert property (s_rdiv_wr ##0 reg_wdata[7:0] != 8'h00 |-> ##2
        (pre_pfd_divide_value == $past(reg_wdata[7:0], 2) && !doubler_on))
        else $error("divide value not applied");
    a_dbl_write: assert property (s_rdiv_wr ##0 reg_wdata[7:0] == 8'h00 |-> ##2
        (doubler_on && pre_pfd_divide_value == 8'h01)) else $error("doubler not on");
    a_dbl_one: assert property (doubler_on |-> pre_pfd_divide_value == 8'h01)
        else $error("doubler with divide not one");
    a_div_range: assert property (!doubler_on |-> pre_pfd_divide_value != 8'h00)
        else $error("divide value zero without doubler");
    a_byp_write: assert property (s_byp_wr |-> ##2
        (bypass_source_sel == $past(reg_wdata[1:0], 2)
        && bypass_chan_buf_on == $past(reg_wdata[7:4], 2)
        && bypass_single_out_on == $past(reg_wdata[8], 2))) else $error("bypass fields wrong");
    a_fb_only_zdm: assert property (ext_fb_pos_en || int_fb_ch2_en |->
        zero_delay_on && !(ext_fb_pos_en && int_fb_ch2_en)) else $error("feedback choice bad");
    a_neg_with_pos: assert property (ext_fb_neg_en |-> ext_fb_pos_en)
        else $error("negative feedback pin alone");
    a_zdm_path: assert property (zero_delay_on |-> ref_is_diff && !doubler_on
        && pre_pfd_divide_value == 8'h01) else $error("zero-delay path settings wrong");
    a_cfg_hold: assert property (!$past(srst) && !$past(reg_wr) && !$past(reg_wr, 2) |->
        $stable(pre_pfd_divide_value) && $stable(bypass_source_sel)) else $error("config drift");
endmodule

bind prps_top prps_chk prps_chk_inst (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_is_diff(ref_is_diff), .doubler_on(doubler_on),
    .pre_pfd_divide_value(pre_pfd_divide_value), .bypass_source_sel(bypass_source_sel),
    .bypass_chan_buf_on(bypass_chan_buf_on), .bypass_single_out_on(bypass_single_out_on),
    .zero_delay_on(zero_delay_on), .ext_fb_pos_en(ext_fb_pos_en),
    .ext_fb_neg_en(ext_fb_neg_en), .int_fb_ch2_en(int_fb_ch2_en));

// ### verification/pll_reference_path_select_bench.sv
// Purpose: Self-checking bench for the reference path selector.
// Assumes: Driver notes expectations in a queue; a monitor compares at negedge.
// Notes: Shadow registers model the stored configuration.
`timescale 1ns/1ps
module pll_reference_path_select_bench import prps_pkg::*;;
    logic ref_clk = 1'b0; // 100 MHz clock
    logic srst = 1'b1; // Held high at start
    logic [ADDR_W-1:0] reg_addr = 4'h0; // Bus address
    logic [DATA_W-1:0] reg_wdata = 32'h0; // Bus write data
    logic reg_wr = 1'b0; // Write strobe
    logic reg_rd = 1'b0; // Read strobe
    logic input_choice_pin = 1'b0; // Select pin
    logic [DATA_W-1:0] reg_rdata, got; // Read data, observed value
    logic ref_is_diff, doubler_on, bypass_single_out_on, zero_delay_on; // Path flags
    logic ext_fb_pos_en, ext_fb_neg_en, int_fb_ch2_en; // Feedback flags
    logic [1:0] xtal_in_type, diff_in_type, bypass_source_sel; // Two-bit fields
    logic [3:0] bypass_chan_buf_on; // Channel buffers
    logic [7:0] pre_pfd_divide_value; // Divide ratio
    logic [7:0] dv[4] = '{8'h00, 8'h01, 8'h02, 8'hFF}; // Divide boundaries
    logic [31:0] rc, rv, bp, zd, seed; // Shadow registers, random state
    logic [32:0] exp_q[$], e; // Expected notes; bit 32 marks a read
    logic rd_taken = 1'b0; // Read taken at last edge
    logic smp = 1'b0; // Output sample requested
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    wire logic [24:0] outs = {ref_is_diff, xtal_in_type, diff_in_type, doubler_on,
        pre_pfd_divide_value, bypass_source_sel, bypass_chan_buf_on, bypass_single_out_on,
        zero_delay_on, ext_fb_pos_en, ext_fb_neg_en, int_fb_ch2_en};
    ////////////////////////////////////////////////////////////////////////////////
    prps_top prps_top_inst (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_choice_pin(input_choice_pin), .ref_is_diff(ref_is_diff),
        .xtal_in_type(xtal_in_type), .diff_in_type(diff_in_type), .doubler_on(doubler_on),
        .pre_pfd_divide_value(pre_pfd_divide_value), .bypass_source_sel(bypass_source_sel),
        .bypass_chan_buf_on(bypass_chan_buf_on), .bypass_single_out_on(bypass_single_out_on),
        .zero_delay_on(zero_delay_on), .ext_fb_pos_en(ext_fb_pos_en),
        .ext_fb_neg_en(ext_fb_neg_en), .int_fb_ch2_en(int_fb_ch2_en));
    // Free-running clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Zero-delay only when every listed setting agrees
    function automatic logic zact();
        return zd[0] & zd[2] & rc[0] & rc[1] & (rv[7:0] == 8'h01);
    endfunction
    function automatic logic rdiff();
        return zact() | (rc[0] ? rc[1] : input_choice_pin);
    endfunction
    function automatic logic [24:0] exp_out();
        logic z;
        z = zact();
        return {rdiff(), rc[5:4], rc[9:8], rv[7:0] == 8'h00,
            (rv[7:0] == 8'h00) ? 8'h01 : rv[7:0], bp[1:0], bp[7:4], bp[8],
            z, z & zd[1], z & zd[1] & zd[3], z & ~zd[1]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks: entered just after a rising edge, one strobe per cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        case (a)
            OFS_REFCTL: rc = d;
            OFS_RDIV: rv = d;
            OFS_BYP: bp = d;
            OFS_ZDM: zd = d;
            default: ; // Status and holes keep nothing
        endcase
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        exp_q.push_back({1'b1, x});
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
    endtask
    // Let path settle past the pin synchroniser, sample outputs, then status
    task automatic chk();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (4) @(posedge ref_clk);
        exp_q.push_back({8'h0, exp_out()});
        smp = 1'b1;
        @(posedge ref_clk);
        smp = 1'b0;
        rd(OFS_STAT, {27'h0, input_choice_pin, zact() & zd[1], zact(), rv[7:0] == 8'h00,
            rdiff()});
    endtask
    task automatic rst();
        reg_rd <= 1'b0;
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rc = 32'h0;
        rv = 32'h1;
        bp = 32'h0;
        zd = 32'h0;
    endtask
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: oldest note against reply or sampled outputs; also hang guard
    always @(posedge ref_clk) begin
        rd_taken <= reg_rd;
    end
    always @(negedge ref_clk) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            stop_test();
        end else if (rd_taken || smp) begin
            got = rd_taken ? reg_rdata : {7'h0, outs};
            e = exp_q.pop_front();
            compares++;
            if (e[31:0] !== got) begin
                fails++;
                $display("unexpected at %0t: got %h expected %h", $time, got, e[31:0]);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hE7A6ABC0;
        rst();
        chk();
        rd(OFS_RDIV, 32'h1);
        rd(4'hF, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_REFCTL, {22'h0, seed[9:8], 2'h0, seed[5:4], 2'h0, i[0], i[1]});
            input_choice_pin <= ~i[0];
            chk();
            seed = lfsr(seed);
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFS_RDIV, {24'h0, dv[i]});
            rd(OFS_RDIV, {24'h0, dv[i]});
            chk();
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFS_BYP, {23'h0, seed[8], seed[7:4], 2'h0, i[1:0]});
            chk();
            seed = lfsr(seed);
        end
        wr(OFS_REFCTL, 32'h3);
        wr(OFS_RDIV, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_ZDM, {28'h0, i[1], 1'b1, i[0], 1'b1});
            chk();
        end
        wr(OFS_RDIV, 32'h2);
        chk();
        wr(OFS_RDIV, 32'h1);
        wr(OFS_ZDM, 32'h3);
        chk();
        wr(OFS_STAT, 32'hFFFFFFFF);
        wr(4'hA, 32'hFFFFFFFF);
        rd(4'hA, 32'h0);
        rd(OFS_ZDM, 32'h3);
        chk();
        rst();
        chk();
        // Drop the strobe and let the last reply reach the monitor
        reg_rd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        stop_test();
    end
endmodule
